// File: logic/mmts_consts.svh
// Constants for the multi-module trigger synchronisation block
`ifndef MMTS_CONSTS_SVH
`define MMTS_CONSTS_SVH
`define MMTS_NLINES      8
`define MMTS_SELW        3
`define MMTS_TRIG_HOLD   4
`define MMTS_HOLDW       3
`define MMTS_SYNC_RST    1'b0
`endif

// File: logic/mmts_pkg.sv
// Types for the multi-module trigger synchronisation block
`include "mmts_consts.svh"
package mmts_pkg;
  typedef enum logic [1:0] {
    MMTS_POST  = 2'b00,
    MMTS_DELAY = 2'b01,
    MMTS_PRE   = 2'b10,
    MMTS_MID   = 2'b11
  } mmts_mode_e;
  typedef enum logic [2:0] {
    MMTS_IDLE  = 3'b000,
    MMTS_FILL  = 3'b001,
    MMTS_ARMED = 3'b010,
    MMTS_WAIT  = 3'b011,
    MMTS_DLY   = 3'b100,
    MMTS_AFTER = 3'b101
  } mmts_state_e;
  typedef struct packed {
    logic                       is_master;
    mmts_mode_e                 mode;
    logic [`MMTS_SELW-1:0]      trig_sel;
    logic [`MMTS_SELW-1:0]      arm_sel;
    logic [`MMTS_NLINES-1:0]    arm_mask;
  } mmts_cfg_s;
endpackage

// File: logic/mmts_sync.sv
// Trigger synchronisation logic for one module of a multi-module group
`timescale 1ns/100ps
`default_nettype none
`include "mmts_consts.svh"
module mmts_sync #(
  parameter int CW = 28,
  parameter int DW = 16
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_ce,
  input  wire mmts_pkg::mmts_cfg_s     i_cfg,
  input  wire logic                    i_start,
  input  wire logic                    i_trig_event,
  input  wire logic                    i_sample_tick,
  input  wire logic [CW-1:0]           i_pre_cnt,
  input  wire logic [CW-1:0]           i_post_cnt,
  input  wire logic [DW-1:0]           i_delay_cnt,
  input  wire logic [`MMTS_NLINES-1:0] i_bus_in,
  output logic [`MMTS_NLINES-1:0]      o_bus_out,
  output logic [`MMTS_NLINES-1:0]      o_bus_oe,
  output logic                         o_acq_start,
  output logic                         o_keep,
  output logic                         o_done,
  output logic                         o_armed,
  output logic                         o_cfg_err,
  output mmts_pkg::mmts_state_e        o_state
);
  import mmts_pkg::*;

  // Widths the counters cannot serve, refused at elaboration
  if (CW < 2 || CW > 32 || DW < 1 || DW > 32) begin : g_bad_width
    $error("mmts_sync: unsupported counter width");
  end

  localparam int NL = `MMTS_NLINES;

  // Three-stage synchronisers with agreement filter per bus line
  logic [NL-1:0] s1_r;            // First stage, read by s2 only
  logic [NL-1:0] s2_r;            // Second stage
  logic [NL-1:0] s3_r;            // Third stage
  logic [NL-1:0] line_r;          // Filtered line level
  logic [NL-1:0] line_nxt;        // Next filtered level

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_sync
      // Filter takes a level once stages two and three agree
      always_comb begin
        line_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : line_r[g];
      end
      // Register the chain
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          s1_r[g]   <= `MMTS_SYNC_RST;
          s2_r[g]   <= `MMTS_SYNC_RST;
          s3_r[g]   <= `MMTS_SYNC_RST;
          line_r[g] <= `MMTS_SYNC_RST;
        end else if (i_ce) begin
          s1_r[g]   <= i_bus_in[g];
          s2_r[g]   <= s1_r[g];
          s3_r[g]   <= s2_r[g];
          line_r[g] <= line_nxt[g];
        end
      end
    end
  endgenerate

  // Role and mode decode
  logic is_hs;        // Own mode needs pre-trigger fill
  logic bad_cfg;      // Slave armed line collides
  logic trig_lvl;     // Synchronised shared trigger level
  logic trig_prev_r;  // Previous trigger level
  logic trig_edge;    // Shared trigger rising edge
  logic all_armed;    // Every participant armed

  always_comb begin
    is_hs     = (i_cfg.mode == MMTS_PRE) || (i_cfg.mode == MMTS_MID);
    bad_cfg   = !i_cfg.is_master && is_hs &&
                (i_cfg.arm_sel == i_cfg.trig_sel);
    trig_lvl  = line_r[i_cfg.trig_sel];
    trig_edge = trig_lvl && !trig_prev_r;
  end

  // Acquisition state and counters
  mmts_state_e   st_r, st_nxt;      // Capture state
  logic [CW-1:0] cnt_r, cnt_nxt;    // Sample counter
  logic [DW-1:0] dly_r, dly_nxt;    // Delay counter
  logic          keep_nxt;          // Sample stored strobe
  logic          done_nxt;          // Capture finished strobe
  logic          start_nxt;         // Acquisition start strobe

  // Master readiness: armed lines in the mask and own fill
  always_comb begin
    all_armed = (&(line_r | ~i_cfg.arm_mask)) &&
                (!is_hs || st_r == MMTS_ARMED);
  end

  // Next capture state
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    dly_nxt   = dly_r;
    keep_nxt  = 1'b0;
    done_nxt  = 1'b0;
    start_nxt = 1'b0;
    case (st_r)
      MMTS_IDLE: begin
        // Start command opens the capture
        if (i_start && !bad_cfg) begin
          cnt_nxt = '0;
          st_nxt  = is_hs ? MMTS_FILL : MMTS_WAIT;
        end
      end
      MMTS_FILL: begin
        // Collect the pre-trigger history first
        if (i_sample_tick) begin
          keep_nxt = 1'b1;
          cnt_nxt  = cnt_r + 1'b1;
        end
        if (cnt_r >= i_pre_cnt) begin
          st_nxt = MMTS_ARMED;
        end
      end
      MMTS_ARMED: begin
        // Ring keeps rolling; only the last samples survive
        keep_nxt = i_sample_tick;
        if (trig_edge) begin
          start_nxt = 1'b1;
          cnt_nxt   = '0;
          if (i_cfg.mode == MMTS_MID && i_post_cnt != '0) begin
            st_nxt = MMTS_AFTER;
          end else begin
            st_nxt   = MMTS_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
      MMTS_WAIT: begin
        // Post and delay modes wait on the shared trigger
        if (trig_edge) begin
          start_nxt = 1'b1;
          cnt_nxt   = '0;
          dly_nxt   = i_delay_cnt;
          if (i_cfg.mode == MMTS_DELAY && i_delay_cnt != '0) begin
            st_nxt = MMTS_DLY;
          end else begin
            st_nxt = MMTS_AFTER;
          end
        end
      end
      MMTS_DLY: begin
        // Delay counts time-base cycles
        dly_nxt = dly_r - 1'b1;
        if (dly_r == {{(DW-1){1'b0}}, 1'b1}) begin
          st_nxt = MMTS_AFTER;
        end
      end
      MMTS_AFTER: begin
        // Samples after the trigger until the count is met
        if (cnt_r >= i_post_cnt) begin
          st_nxt   = MMTS_IDLE;
          done_nxt = 1'b1;
        end else if (i_sample_tick) begin
          keep_nxt = 1'b1;
          cnt_nxt  = cnt_r + 1'b1;
        end
      end
      default: begin
        st_nxt = MMTS_IDLE;
      end
    endcase
  end

  // Register capture state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r        <= MMTS_IDLE;
      cnt_r       <= '0;
      dly_r       <= '0;
      trig_prev_r <= 1'b0;
      o_keep      <= 1'b0;
      o_done      <= 1'b0;
      o_acq_start <= 1'b0;
      o_state     <= MMTS_IDLE;
    end else if (i_ce) begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      dly_r       <= dly_nxt;
      trig_prev_r <= trig_lvl;
      o_keep      <= keep_nxt;
      o_done      <= done_nxt;
      o_acq_start <= start_nxt;
      o_state     <= st_nxt;
    end
  end

  // Master trigger release and line drive
  logic                   pend_r, pend_nxt;  // Trigger held back
  logic [`MMTS_HOLDW-1:0] hold_r, hold_nxt;  // Pulse width count
  logic                   fire;              // Release this cycle
  logic [NL-1:0]          out_nxt;           // Next line levels
  logic [NL-1:0]          oe_nxt;            // Next line enables
  logic                   armed_nxt;         // Next armed level

  always_comb begin
    fire     = i_cfg.is_master && pend_r && all_armed &&
               hold_r == '0;
    // A new event in the release cycle is kept
    pend_nxt = (i_cfg.is_master && i_trig_event) ||
               (pend_r && !fire);
    hold_nxt = hold_r;
    if (fire) begin
      hold_nxt = `MMTS_HOLDW'(`MMTS_TRIG_HOLD);
    end else if (hold_r != '0) begin
      hold_nxt = hold_r - 1'b1;
    end
    armed_nxt = !i_cfg.is_master && is_hs && !bad_cfg &&
                st_nxt == MMTS_ARMED;
    out_nxt = '0;
    oe_nxt  = '0;
    if (i_cfg.is_master) begin
      oe_nxt[i_cfg.trig_sel]  = 1'b1;
      out_nxt[i_cfg.trig_sel] = hold_nxt != '0;
    end else if (is_hs && !bad_cfg) begin
      oe_nxt[i_cfg.arm_sel]  = 1'b1;
      out_nxt[i_cfg.arm_sel] = armed_nxt;
    end
  end

  // Register master drive and slave armed line
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pend_r    <= 1'b0;
      hold_r    <= '0;
      o_bus_out <= '0;
      o_bus_oe  <= '0;
      o_armed   <= 1'b0;
      o_cfg_err <= 1'b0;
    end else if (i_ce) begin
      pend_r    <= pend_nxt;
      hold_r    <= hold_nxt;
      o_bus_out <= out_nxt;
      o_bus_oe  <= oe_nxt;
      o_armed   <= armed_nxt;
      o_cfg_err <= bad_cfg;
    end
  end

  // Checks on the handshake and capture
  // Rising trigger on the pin must follow a cycle with all lines armed
  chk_hold_until_armed: assert property (@(posedge i_clk)
    disable iff (i_reset)
    i_cfg.is_master && $stable(i_cfg) &&
    $rose(o_bus_out[i_cfg.trig_sel]) |-> $past(all_armed && pend_r))
    else $error("trigger released before all armed");
  chk_master_one_line: assert property (@(posedge i_clk)
    disable iff (i_reset)
    i_ce && i_cfg.is_master |=> $onehot(o_bus_oe) || !i_ce)
    else $error("master drives other than one line");
  chk_pulse_width: assert property (@(posedge i_clk)
    disable iff (i_reset)
    i_ce && fire ##1 i_ce [*4] |=> hold_r == '0)
    else $error("trigger pulse width wrong");
  chk_arm_not_trig: assert property (@(posedge i_clk)
    disable iff (i_reset)
    !i_cfg.is_master && $stable(i_cfg) && $past(i_ce) |->
    !o_bus_oe[i_cfg.trig_sel])
    else $error("slave drives the trigger line");
  chk_armed_state: assert property (@(posedge i_clk)
    disable iff (i_reset)
    o_armed |-> st_r == MMTS_ARMED)
    else $error("armed shown outside armed state");
  chk_trig_starts: assert property (@(posedge i_clk)
    disable iff (i_reset)
    i_ce && st_r == MMTS_WAIT && trig_edge |=> o_acq_start)
    else $error("trigger did not start acquisition");
  chk_fill_no_trig: assert property (@(posedge i_clk)
    disable iff (i_reset)
    i_ce && st_r == MMTS_FILL |=> !o_acq_start)
    else $error("trigger taken before history filled");
  chk_sync_agree: assert property (@(posedge i_clk)
    disable iff (i_reset)
    i_ce && s2_r != s3_r |=> $stable(line_r) || !$past(i_ce))
    else $error("line taken before stages agree");
  chk_mid_after: assert property (@(posedge i_clk)
    disable iff (i_reset)
    i_ce && st_r == MMTS_AFTER && cnt_r >= i_post_cnt |=> o_done)
    else $error("post count not ended");
endmodule
`default_nettype wire

// File: verif/mmts_peer.sv
// Far-side model: another module on the shared chassis lines
`timescale 1ns/100ps
`default_nettype none
module mmts_peer #(
  parameter int HOLD = 3  // Trigger pulse length in cycles
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_master,  // Acts as group master
  input  wire logic       i_fire,    // Send one start trigger
  input  wire logic       i_arm,     // Armed level as a slave
  input  wire logic [2:0] i_tsel,    // Trigger line
  input  wire logic [2:0] i_asel,    // Own armed line
  output logic [7:0]      o_out,
  output logic [7:0]      o_oe
);
  int hold_r;  // Remaining pulse cycles
  // Pulse timer for the shared start trigger
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) hold_r <= 0;
    else if (i_fire && i_master) hold_r <= HOLD;
    else if (hold_r > 0) hold_r <= hold_r - 1;
  end
  // Master drives the trigger line, a slave its own armed line
  always_comb begin
    o_out = '0;
    o_oe  = '0;
    o_out[i_tsel] = hold_r > 0;
    if (i_master) o_oe[i_tsel] = 1'b1;
    else begin
      o_oe[i_asel]  = 1'b1;
      o_out[i_asel] = i_arm;
    end
  end
endmodule
`default_nettype wire

// File: verif/mmts_sync_tb.sv
// Self-checking bench for the trigger synchronisation block
`timescale 1ns/100ps
`default_nettype none
`include "mmts_consts.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_errors++; $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); \
  end end
module mmts_sync_tb;
  import mmts_pkg::*;
  logic        i_clk, i_reset, i_start, i_trig_event;
  logic        tick_p, tick_run, p_master, p_fire, p_arm;
  mmts_cfg_s   cfg;
  logic [7:0]  d_out, d_oe, p_out, p_oe, bus;
  logic        acq, keep, done, armed, cerr, ce;
  logic [2:0]  ev;
  mmts_state_e st;
  int n_errors = 0, samples_checked = 0, n_keep = 0, n_hi = 0, b, h;
  assign ev = {done, armed, acq};
  // Line levels: a driver wins, released lines are pulled low
  always_comb
    for (int i = 0; i < 8; i++)
      bus[i] = d_oe[i] ? d_out[i] : (p_oe[i] ? p_out[i] : 1'b0);
  mmts_sync mmts_sync_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_cfg(cfg),
    .i_start(i_start), .i_trig_event(i_trig_event),
    .i_sample_tick(tick_p | tick_run), .i_pre_cnt(28'h3),
    .i_post_cnt(28'h4), .i_delay_cnt(16'h5), .i_bus_in(bus),
    .o_bus_out(d_out), .o_bus_oe(d_oe), .o_acq_start(acq),
    .o_keep(keep), .o_done(done), .o_armed(armed),
    .o_cfg_err(cerr), .o_state(st));
  mmts_peer mmts_peer_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_master(p_master),
    .i_fire(p_fire), .i_arm(p_arm), .i_tsel(p_master ? 3'd2 : 3'd1),
    .i_asel(3'd4), .o_out(p_out), .o_oe(p_oe));
  initial begin
    i_clk = 0;
    forever #20 i_clk = ~i_clk;
  end
  // Kept samples and master trigger-line high cycles
  always @(posedge i_clk) begin
    n_keep <= n_keep + int'(keep);
    n_hi   <= n_hi + int'(d_out[1] & d_oe[1]);
  end
  // Samples run freely once the capture is triggered
  always @(negedge i_clk) if (acq === 1'b1) tick_run <= 1'b1;
  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1'b1;
    @(negedge i_clk) s = 1'b0;
  endtask
  // Bounded wait for one output event
  task automatic wait_ev(input int k);
    int n;
    for (n = 0; n < 400; n++) begin
      @(negedge i_clk);
      if (ev[k] === 1'b1) break;
    end
    if (n == 400) `CHK(n, 0)
  endtask
  // Single ticks until the armed output rises, at most 20
  task automatic fill();
    repeat (20) if (armed !== 1'b1) begin
      pulse(tick_p);
      @(negedge i_clk);
    end
  endtask
  task automatic setup(input mmts_cfg_s c);
    repeat (3) @(negedge i_clk);
    cfg = c;
    tick_run = 0;
    b = n_keep;
    h = n_hi;
    @(negedge i_clk);
  endtask
  task automatic run_slave(input mmts_mode_e m);
    setup('{1'b0, m, 3'd2, 3'd5, 8'h00});
    pulse(i_start);
    if (m[1]) begin
      fill();
      `CHK(armed, 1'b1)
      `CHK(d_out[5], 1'b1)
    end
    `CHK(d_oe, m[1] ? 8'h20 : 8'h00)
    pulse(p_fire);
    wait_ev(2);
    @(negedge i_clk);
    `CHK(n_keep - b, m == MMTS_PRE ? 3 : m == MMTS_MID ? 7 : 4)
    $display("test slave mode %0d done", m);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    results();
  end
  initial begin
    {i_start, i_trig_event, tick_p, tick_run, p_fire, p_arm} = '0;
    ce = 1;
    p_master = 1;
    cfg = '0;
    i_reset = 1;
    repeat (2) @(negedge i_clk);
    i_reset = 0;
    for (int m = 0; m < 4; m++) run_slave(mmts_mode_e'(m));
    // Armed line on the trigger line is refused
    setup('{1'b0, MMTS_MID, 3'd3, 3'd3, 8'h00});
    pulse(i_start);
    `CHK(cerr, 1'b1)
    `CHK(st, MMTS_IDLE)
    $display("test config error done");
    // Enable low freezes state: start is lost, idle ignores trigger
    setup('{1'b0, MMTS_POST, 3'd2, 3'd5, 8'h00});
    ce = 0;
    pulse(i_start);
    ce = 1;
    `CHK(st, MMTS_IDLE)
    pulse(p_fire);
    repeat (10) @(negedge i_clk);
    `CHK(st, MMTS_IDLE)
    `CHK(n_keep - b, 0)
    $display("test clock enable done");
    // Master in post mode drives one line, one pulse
    p_master = 0;
    setup('{1'b1, MMTS_POST, 3'd1, 3'd0, 8'h00});
    `CHK(d_oe, 8'h02)
    pulse(i_start);
    pulse(i_trig_event);
    wait_ev(2);
    @(negedge i_clk);
    `CHK(n_hi - h, `MMTS_TRIG_HOLD)
    `CHK(n_keep - b, 4)
    $display("test master post done");
    // Master in pre mode waits for the slave armed line
    setup('{1'b1, MMTS_PRE, 3'd1, 3'd0, 8'h10});
    pulse(i_start);
    fill();
    pulse(i_trig_event);
    repeat (20) @(negedge i_clk);
    `CHK(n_hi - h, 0)
    `CHK(acq, 1'b0)
    p_arm = 1;
    wait_ev(2);
    repeat (8) @(negedge i_clk);
    `CHK(n_hi - h, `MMTS_TRIG_HOLD)
    $display("test master handshake done");
    results();
  end
endmodule
`default_nettype wire
